// File: rtl/serial_status_params.svh
// constants for the serial status flag block
`ifndef SERIAL_STATUS_PARAMS_SVH
`define SERIAL_STATUS_PARAMS_SVH
`define OFS_STATUS_ONE    8'h04
`define OFS_DATA_LOW      8'h00
`define OFS_CONTROL       8'h08
`define OFS_IRQ_STATUS    8'h0C
`define OFS_IRQ_MASK      8'h10
`define BIT_TX_EMPTY      7
`define BIT_TX_DONE       6
`define BIT_RX_FULL       5
`define BIT_IDLE          4
`define CTL_LONG_FRAME    0
`define CTL_WAKEUP        1
`define CTL_BREAK         2
`define CTL_PREAMBLE      3
`define IDLE_BITS_SHORT   4'hA
`define IDLE_BITS_LONG    4'hB
`define BAUD_DIV_RESET    16'h0010
`define RESET_STATUS_ONE  8'hC0
`endif

// File: rtl/serial_status_pkg.sv
// types shared by the serial status flag block
package serial_status_pkg;
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_SHIFT = 2'b01,
      TX_SPECIAL = 2'b10
   } tx_state_t;
endpackage

// File: rtl/serial_bit_tick.sv
// baud tick divider: one-cycle enable pulse every div cycles
`timescale 1ns/1ps
`default_nettype none
module serial_bit_tick #(
   parameter int W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_reg;
   // counter restarts at zero so tick spacing equals div
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else if (cnt_reg + 1'b1 >= div) begin
         cnt_reg <= '0;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         tick    <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: rtl/serial_rx_shift.sv
// receive shifter with idle-run counter, one sample per tick
`include "serial_status_params.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_rx_shift (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       tick,
   input  wire logic       long_frame,
   input  wire logic       rxd,
   output logic            done,
   output logic [7:0]      data,
   output logic            idle_seen
);
   logic [3:0] bit_reg;
   logic [3:0] ones_reg;
   logic [8:0] sh_reg;
   logic [3:0] last_bit;
   logic [3:0] idle_need;
   assign last_bit  = long_frame ? 4'd10 : 4'd9;
   assign idle_need = long_frame ? `IDLE_BITS_LONG : `IDLE_BITS_SHORT;
   // frame capture: start bit low, data lsb first, stop bit checked high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_reg <= '0;
         sh_reg  <= '0;
         done    <= 1'b0;
         data    <= '0;
      end else begin
         done <= 1'b0;
         if (tick) begin
            if (bit_reg == 4'd0) begin
               if (!rxd) bit_reg <= 4'd1;
            end else if (bit_reg == last_bit) begin
               bit_reg <= 4'd0;
               // a missing stop bit means a bad frame, not delivered
               if (rxd) begin
                  done <= 1'b1;
                  // short frames shift eight times, so the byte sits one bit higher
                  data <= long_frame ? sh_reg[7:0] : sh_reg[8:1];
               end
            end else begin
               sh_reg  <= {rxd, sh_reg[8:1]};
               bit_reg <= bit_reg + 4'd1;
            end
         end
      end
   end
   // consecutive-ones counter saturates at the idle length
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_reg  <= '0;
         idle_seen <= 1'b0;
      end else begin
         idle_seen <= 1'b0;
         if (tick) begin
            if (!rxd) begin
               ones_reg <= '0;
            end else if (ones_reg + 4'd1 == idle_need) begin
               ones_reg  <= ones_reg + 4'd1;
               idle_seen <= 1'b1;
            end else if (ones_reg < idle_need) begin
               ones_reg <= ones_reg + 4'd1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/serial_status_top.sv
// serial port status flags with avalon-mm register slave
//
// Overview of operation
// - status register readable any time, writes to it are ignored
// - transmit-empty bit 7 sets when the shifter takes the data byte
// - transmit-empty clears on status read seeing it, then data low write
// - transmit-complete bit 6 low while sending, high when empty and idle
// - serial output is high whenever transmit-complete is set
// - transmit-complete clears on queueing or status read then data write
// - simultaneous set and clear of transmit-complete leaves it clear
// - receive-full bit 5 sets when received byte enters data register
// - receive-full clears on status read seeing it, then data low read
// - idle bit 4 sets after 10 or 11 high bits by frame length
// - after idle clears, a valid frame must set receive-full before re-arm
// - idle clears on status read seeing it, then data low read
// - receiver wakeup bit set blocks idle flag from setting
// - flags drive the interrupt logic and stay readable for polling
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`include "serial_status_params.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_status_top
   import serial_status_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////
   // reset release and bus timing
   logic       rst_meta_reg;
   logic       rst_n;
   // two flops so reset leaves every flop on the same edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   logic ack_reg;
   // one wait cycle: request taken on the edge where waitrequest is low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ack_reg <= 1'b0;
      else        ack_reg <= (read | write) & ~ack_reg;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) waitrequest <= 1'b1;
      else        waitrequest <= ~((read | write) & ~ack_reg);
   end
   logic rd_go;
   logic wr_go;
   assign rd_go = read & ack_reg;
   assign wr_go = write & ack_reg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // control, baud and data registers
   logic [3:0]  ctl_reg;
   logic [15:0] div_reg;
   logic [7:0]  tx_data_reg;
   logic [7:0]  rx_data_reg;
   logic [3:0]  irq_mask_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg      <= '0;
         div_reg      <= `BAUD_DIV_RESET;
         irq_mask_reg <= '0;
      end else if (wr_go) begin
         if (hit(address, `OFS_CONTROL))  ctl_reg <= writedata[3:0];
         if (hit(address, `OFS_CONTROL))  div_reg <= writedata[31:16];
         if (hit(address, `OFS_IRQ_MASK)) irq_mask_reg <= writedata[7:4];
      end
   end
   logic data_wr;
   logic data_rd;
   logic status_rd;
   assign data_wr   = wr_go & hit(address, `OFS_DATA_LOW);
   assign data_rd   = rd_go & hit(address, `OFS_DATA_LOW);
   assign status_rd = rd_go & hit(address, `OFS_STATUS_ONE);
   logic special_req;
   assign special_req = wr_go & hit(address, `OFS_CONTROL)
                      & (writedata[`CTL_BREAK] | writedata[`CTL_PREAMBLE]);

   logic tick;
   serial_bit_tick #(.W(16)) u_tick (
      .clk   (clk),
      .rst_n (rst_n),
      .div   (div_reg),
      .tick  (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // flags and armed-by-read bits
   logic tx_empty_reg;
   logic tx_done_reg;
   logic rx_full_reg;
   logic idle_reg;
   logic idle_arm_reg;
   logic [3:0] seen_reg;   // flags observed set by last status read
   logic tx_take;
   logic tx_busy;
   logic queued_reg;
   logic rx_done;
   logic [7:0] rx_byte;
   logic idle_seen;

   // gap allowed: seen bits persist until the data access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) seen_reg <= '0;
      else if (status_rd) seen_reg <= {tx_empty_reg, tx_done_reg, rx_full_reg, idle_reg};
      else if (data_wr) seen_reg[3:2] <= 2'b00;
      else if (data_rd) seen_reg[1:0] <= 2'b00;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_empty_reg <= 1'b1;
      else if (tx_take) tx_empty_reg <= 1'b1;
      else if (data_wr & seen_reg[3]) tx_empty_reg <= 1'b0;
   end

   // data write loads the holding register; queued until shifter takes it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data_reg <= '0;
         queued_reg  <= 1'b0;
      end else if (data_wr) begin
         tx_data_reg <= writedata[7:0];
         queued_reg  <= 1'b1;
      end else if (tx_take) begin
         queued_reg  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_done_reg <= 1'b1;
      else if (data_wr | special_req | tx_busy | queued_reg) tx_done_reg <= 1'b0;
      else if (tx_empty_reg) tx_done_reg <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_reg <= 1'b0;
         rx_data_reg <= '0;
      end else if (rx_done) begin
         rx_full_reg <= 1'b1;
         rx_data_reg <= rx_byte;
      end else if (data_rd & seen_reg[1]) begin
         rx_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg     <= 1'b0;
         idle_arm_reg <= 1'b0;
      end else begin
         if (rx_done) idle_arm_reg <= 1'b1;
         if (idle_seen & idle_arm_reg & ~ctl_reg[`CTL_WAKEUP]) begin
            idle_reg     <= 1'b1;
            idle_arm_reg <= 1'b0;
         end else if (data_rd & seen_reg[0]) begin
            idle_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // transmit shifter
   tx_state_t  tx_state_reg;
   logic [3:0] tx_cnt_reg;
   logic [9:0] tx_sh_reg;
   assign tx_busy = (tx_state_reg != TX_IDLE);
   assign tx_take = (tx_state_reg == TX_IDLE) & queued_reg & tick;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg <= TX_IDLE;
         tx_cnt_reg   <= '0;
         tx_sh_reg    <= '1;
      end else begin
         unique case (tx_state_reg)
            TX_IDLE: begin
               if (special_req) begin
                  // preamble all ones, break ten zeros then ones, one frame long
                  tx_sh_reg    <= writedata[`CTL_BREAK] ? 10'h000 : 10'h3FF;
                  tx_cnt_reg   <= ctl_reg[`CTL_LONG_FRAME] ? 4'd11 : 4'd10;
                  tx_state_reg <= TX_SPECIAL;
               end else if (tx_take) begin
                  tx_sh_reg    <= {1'b1, tx_data_reg, 1'b0};
                  tx_cnt_reg   <= ctl_reg[`CTL_LONG_FRAME] ? 4'd11 : 4'd10;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            TX_SHIFT, TX_SPECIAL: begin
               if (tick) begin
                  tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                  tx_cnt_reg <= tx_cnt_reg - 4'd1;
                  if (tx_cnt_reg == 4'd1) tx_state_reg <= TX_IDLE;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) txd <= 1'b1;
      else        txd <= tx_busy ? tx_sh_reg[0] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // receiver
   serial_rx_shift u_rx (
      .clk        (clk),
      .rst_n      (rst_n),
      .tick       (tick),
      .long_frame (ctl_reg[`CTL_LONG_FRAME]),
      .rxd        (rxd),
      .done       (rx_done),
      .data       (rx_byte),
      .idle_seen  (idle_seen)
   );

   ////////////////////////////////////////////////////////////////////
   // interrupt status: sticky, cleared by reading it; set wins
   logic [3:0] irq_stat_reg;
   logic [3:0] flag_now;
   logic [3:0] flag_prev_reg;
   logic       irq_stat_rd;
   assign flag_now    = {tx_empty_reg, tx_done_reg, rx_full_reg, idle_reg};
   assign irq_stat_rd = rd_go & hit(address, `OFS_IRQ_STATUS);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) flag_prev_reg <= 4'b1100;
      else        flag_prev_reg <= flag_now;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) irq_stat_reg <= '0;
      else irq_stat_reg <= (irq_stat_rd ? 4'b0000 : irq_stat_reg)
                           | (flag_now & ~flag_prev_reg);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) irq <= 1'b0;
      else        irq <= |(irq_stat_reg & irq_mask_reg);
   end

   ////////////////////////////////////////////////////////////////////
   // read mux, registered; unmapped addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) readdata <= '0;
      else if (read & ~ack_reg) begin
         unique case (address)
            `OFS_STATUS_ONE: readdata <= {24'h0, flag_now, 4'h0};
            `OFS_DATA_LOW:   readdata <= {24'h0, rx_data_reg};
            `OFS_CONTROL:    readdata <= {div_reg, 12'h0, ctl_reg};
            `OFS_IRQ_STATUS: readdata <= {24'h0, irq_stat_reg, 4'h0};
            `OFS_IRQ_MASK:   readdata <= {24'h0, irq_mask_reg, 4'h0};
            default:         readdata <= '0;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: sim/serial_status_sva.sv
// checker for the serial status block ports
`timescale 1ns/1ps
`default_nettype none
module serial_status_sva (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        irq
);
   logic acc_any;
   logic st_rd;
   // helper terms: any request, and a status read at its answer edge
   assign acc_any = read | write;
   assign st_rd   = read && !waitrequest && address == 8'h04;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////
   bus_answer_a: assert property (
      acc_any && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("request not answered in one cycle");
   wait_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   status_pad_a: assert property (
      st_rd |-> readdata[31:8] == 24'h00_0000 && readdata[3:0] == 4'h0)
      else $error("status unused bits not zero");
   done_empty_a: assert property (st_rd && readdata[6] |-> readdata[7])
      else $error("transmit complete without transmit empty");
   done_line_a: assert property (st_rd && readdata[6] |-> txd)
      else $error("txd low while transmit complete");
   unmapped_zero_a: assert property (
      read && !waitrequest && address == 8'h20 |-> readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   read_hold_a: assert property (read && !waitrequest |=> $stable(readdata))
      else $error("read data changed after answer");
   irq_clear_a: assert property (
      $fell(irq) |-> $past(acc_any) || $past(acc_any, 2) || $past(acc_any, 3))
      else $error("irq dropped without register access");
endmodule
bind serial_status_top serial_status_sva serial_status_sva_inst (
   .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire

// File: sim/serial_line_model.sv
// remote serial partner: sends frames on rxd, decodes frames on txd
`timescale 1ns/1ps
`default_nettype none
module serial_line_model #(
   parameter int BIT_CYCLES = 16
) (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] got[$];
   logic [7:0] sh;
   // line idles high, as if pulled up
   initial rxd = 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   // one frame: start bit, eight data bits lsb first, stop bit
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CYCLES) @(posedge clk);
      end
   endtask
   // decode at mid bit; push after bit 7 so a back-to-back start is not missed
   initial forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         sh[i] = txd;
      end
      got.push_back(sh);
   end
endmodule
`default_nettype wire

// File: sim/serial_status_top_tb_top.sv
// testbench for the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module serial_status_top_tb_top;
   logic        clk, nrst, read, write, rxd, txd, irq, waitrequest;
   logic [7:0]  address;
   logic [31:0] writedata, readdata, d;
   int          miscompares, comparisons;
   serial_status_top serial_status_top_inst (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .rxd(rxd), .txd(txd), .irq(irq));
   serial_line_model #(.BIT_CYCLES(16)) serial_line_model_inst (.clk(clk), .txd(txd),
      .rxd(rxd));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one avalon access; starts on an edge so strobes never change twice per step
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= wd;
      read <= !w;
      write <= w;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) miscompares++;
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      acc(1'b0, a, 32'h0000_0000);
      chk(nm, d, e);
   endtask
   // poll status until all bits of m are set, bounded
   task automatic poll(input logic [31:0] m);
      for (int k = 0; k < 400; k++) begin
         acc(1'b0, 8'h04, 32'h0000_0000);
         if ((d & m) === m) break;
      end
      chk("status poll", d & m, m);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog sized well above the few frames the tests send
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0000_0000;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(8'h04, 32'h0000_00C0, "reset status");
      acc(1'b1, 8'h04, 32'h0000_00FF);
      rd_chk(8'h04, 32'h0000_00C0, "status after write");
      rd_chk(8'h20, 32'h0000_0000, "unmapped");
      $display("test registers done");
      acc(1'b1, 8'h00, 32'h0000_0055);
      poll(32'h0000_0080);
      acc(1'b1, 8'h00, 32'h0000_00A6);
      rd_chk(8'h04, 32'h0000_0000, "status with byte queued");
      poll(32'h0000_0040);
      chk("status after send", d, 32'h0000_00C0);
      chk("txd idle", txd, 1'b1);
      chk("frames", serial_line_model_inst.got.size(), 2);
      chk("first byte", serial_line_model_inst.got[0], 8'h55);
      chk("second byte", serial_line_model_inst.got[1], 8'hA6);
      $display("test transmit done");
      serial_line_model_inst.send(8'hA3);
      poll(32'h0000_0030);
      chk("status full idle", d, 32'h0000_00F0);
      chk("masked irq", irq, 1'b0);
      rd_chk(8'h00, 32'h0000_00A3, "rx byte");
      rd_chk(8'h04, 32'h0000_00C0, "status cleared");
      repeat (480) @(posedge clk);
      rd_chk(8'h04, 32'h0000_00C0, "idle not rearmed");
      $display("test receive done");
      acc(1'b0, 8'h0C, 32'h0000_0000);
      acc(1'b1, 8'h10, 32'h0000_0020);
      serial_line_model_inst.send(8'h3C);
      repeat (400) @(posedge clk);
      chk("irq raised", irq, 1'b1);
      rd_chk(8'h00, 32'h0000_003C, "rx byte unpolled");
      rd_chk(8'h04, 32'h0000_00F0, "flags kept");
      acc(1'b0, 8'h00, 32'h0000_0000);
      acc(1'b0, 8'h0C, 32'h0000_0000);
      chk("irq status", d & 32'h0000_0020, 32'h0000_0020);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      rd_chk(8'h04, 32'h0000_00C0, "status cleared again");
      acc(1'b1, 8'h10, 32'h0000_0000);
      $display("test order and irq done");
      acc(1'b1, 8'h08, 32'h0010_0002);
      serial_line_model_inst.send(8'h81);
      repeat (480) @(posedge clk);
      acc(1'b0, 8'h04, 32'h0000_0000);
      chk("idle under wakeup", d & 32'h0000_0010, 32'h0000_0000);
      acc(1'b0, 8'h00, 32'h0000_0000);
      acc(1'b1, 8'h08, 32'h0010_0000);
      $display("test wakeup done");
      give_verdict;
   end
endmodule
`default_nettype wire
